// ===== dpr_map.svh
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define DPR_DW          36
`define DPR_AW          10
`define DPR_PAW         11
`define DPR_NBYTE       4
`define DPR_BYTE        9
`define DPR_CASC_BIT    10
`define DPR_HALF_MSB    8
`define DPR_DEPTH       1024
`define DPR_DATA_RST    36'h0_0000_0000

// ----------------------------------------------------------------------
// Register map, word index is awaddr[3:2]
// ----------------------------------------------------------------------
`define DPR_IDX_CTRL    2'h0
`define DPR_IDX_STAT    2'h1
`define DPR_CTRL_RST    32'h0000_0000
`define DPR_F_SPLIT     0
`define DPR_F_PIPE_A    1
`define DPR_F_PIPE_B    2
`define DPR_F_WM_A      3
`define DPR_F_WM_B      5
`define DPR_F_LOFF_A    7
`define DPR_F_LOFF_B    8
`define DPR_F_CASC      9
`define DPR_F_SLEEP     0
`define DPR_F_COLL      1
`define DPR_RESP_OKAY   2'h0
`define DPR_RESP_SLVERR 2'h2

`endif

// ===== dpr_pkg.sv
package dpr_pkg;
    typedef enum logic [1:0] {
        DPR_WM_READ_FIRST  = 2'h0,
        DPR_WM_WRITE_FIRST = 2'h1,
        DPR_WM_NO_CHANGE   = 2'h2
    } dpr_wmode_t;
endpackage

// ===== dpr_ram.sv
`timescale 1ns/1ps
`include "dpr_map.svh"

module dpr_ram
    import dpr_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic                    port_a_en,
    input  wire logic [`DPR_NBYTE-1:0]   port_a_we,
    input  wire logic [`DPR_PAW-1:0]     port_a_addr,
    input  wire logic [`DPR_DW-1:0]      port_a_wdata,
    output logic      [`DPR_DW-1:0]      port_a_rdata,
    input  wire logic                    port_b_en,
    input  wire logic [`DPR_NBYTE-1:0]   port_b_we,
    input  wire logic [`DPR_PAW-1:0]     port_b_addr,
    input  wire logic [`DPR_DW-1:0]      port_b_wdata,
    output logic      [`DPR_DW-1:0]      port_b_rdata,
    input  wire logic [`DPR_DW-1:0]      casc_a_in,
    input  wire logic [`DPR_DW-1:0]      casc_b_in,
    output logic      [`DPR_DW-1:0]      casc_a_out,
    output logic      [`DPR_DW-1:0]      casc_b_out,
    input  wire logic                    power_gate,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic      [1:0]              s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic      [31:0]             s_axi_rdata,
    output logic      [1:0]              s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    // ------------------------------------------------------------------
    // Port input registers
    // ------------------------------------------------------------------
    logic [1:0]                        en_reg,    en_next;
    logic [1:0][`DPR_NBYTE-1:0]        we_reg,    we_next;
    logic [1:0][`DPR_PAW-1:0]          addr_reg,  addr_next;
    logic [1:0][`DPR_DW-1:0]           wdata_reg, wdata_next;
    logic [1:0][`DPR_DW-1:0]           casc_reg,  casc_next;
    logic                              sleep_reg, sleep_next;

    always_comb begin
        en_next    = {port_b_en, port_a_en};
        we_next    = {port_b_we, port_a_we};
        addr_next  = {port_b_addr, port_a_addr};
        wdata_next = {port_b_wdata, port_a_wdata};
        casc_next  = {casc_b_in, casc_a_in};
        sleep_next = power_gate;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            en_reg    <= '0;
            we_reg    <= '0;
            addr_reg  <= '0;
            wdata_reg <= '0;
            casc_reg  <= '0;
            sleep_reg <= 1'b0;
        end else begin
            en_reg    <= en_next;
            we_reg    <= we_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            casc_reg  <= casc_next;
            sleep_reg <= sleep_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and status
    // ------------------------------------------------------------------
    logic [31:0]       ctrl_reg, ctrl_next;
    logic              coll_reg, coll_next;
    logic [1:0]        cfg_pipe, cfg_loff;
    dpr_wmode_t        cfg_wm [2];
    logic              cfg_split, cfg_casc;

    always_comb begin
        cfg_split = ctrl_reg[`DPR_F_SPLIT];
        cfg_casc  = ctrl_reg[`DPR_F_CASC];
        cfg_pipe  = {ctrl_reg[`DPR_F_PIPE_B], ctrl_reg[`DPR_F_PIPE_A]};
        cfg_loff  = {ctrl_reg[`DPR_F_LOFF_B], ctrl_reg[`DPR_F_LOFF_A]};
        cfg_wm[0] = dpr_wmode_t'(ctrl_reg[`DPR_F_WM_A +: 2]);
        cfg_wm[1] = dpr_wmode_t'(ctrl_reg[`DPR_F_WM_B +: 2]);
    end

    // ------------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------------
    // No reset on the array: stored words survive a logic reset
    logic [`DPR_DW-1:0]                mem [`DPR_DEPTH];
    logic [1:0]                        acc, wr, csel;
    logic [1:0][`DPR_AW-1:0]           eaddr;
    logic [1:0][`DPR_DW-1:0]           old_w, new_w;
    logic [1:0][`DPR_DW-1:0]           lat_reg,  lat_next;
    logic [1:0][`DPR_DW-1:0]           dout_reg, dout_next;
    logic                              coll_evt;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            csel[p] = cfg_casc & addr_reg[p][`DPR_CASC_BIT];
            // Latch-off reads every cycle the array is not gated; writes still need the enable
            acc[p]  = (en_reg[p] | cfg_loff[p]) & ~sleep_reg;
            wr[p]   = en_reg[p] & (|we_reg[p]) & ~sleep_reg & ~csel[p];
            if (cfg_split)
                eaddr[p] = {p[0], addr_reg[p][`DPR_HALF_MSB:0]};
            else
                eaddr[p] = addr_reg[p][`DPR_AW-1:0];
            old_w[p] = mem[eaddr[p]];
            for (int b = 0; b < `DPR_NBYTE; b++)
                new_w[p][b*`DPR_BYTE +: `DPR_BYTE] = we_reg[p][b]
                    ? wdata_reg[p][b*`DPR_BYTE +: `DPR_BYTE]
                    : old_w[p][b*`DPR_BYTE +: `DPR_BYTE];
            lat_next[p] = lat_reg[p];
            if (acc[p]) begin
                if (csel[p]) begin
                    lat_next[p] = casc_reg[p];
                end else if (wr[p]) begin
                    case (cfg_wm[p])
                        DPR_WM_WRITE_FIRST: lat_next[p] = new_w[p];
                        DPR_WM_NO_CHANGE:   lat_next[p] = lat_reg[p];
                        default:            lat_next[p] = old_w[p];
                    endcase
                end else begin
                    lat_next[p] = old_w[p];
                end
            end
            // Extra stage buys clock rate for one cycle of latency
            dout_next[p] = cfg_pipe[p] ? lat_reg[p] : lat_next[p];
        end
        coll_evt = wr[0] & wr[1] & (eaddr[0] == eaddr[1]);
    end

    // Port B wins a same-address collision; its merged word is stored
    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++)
            if (wr[p])
                mem[eaddr[p]] <= new_w[p];
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lat_reg  <= '0;
            dout_reg <= '0;
        end else begin
            lat_reg  <= lat_next;
            dout_reg <= dout_next;
        end
    end

    assign port_a_rdata = dout_reg[0];
    assign port_b_rdata = dout_reg[1];
    assign casc_a_out   = lat_reg[0];
    assign casc_b_out   = lat_reg[1];

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic        aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [1:0]  aw_idx_reg, aw_idx_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        awready_reg, awready_next, wready_reg, wready_next;
    logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        do_wr;
    logic [1:0]  ar_idx;

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        aw_idx_next  = aw_idx_reg;
        wd_next      = wd_reg;
        ws_next      = ws_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        ctrl_next    = ctrl_reg;
        ar_idx       = s_axi_araddr[3:2];
        // Set wins over a software clear in the same cycle
        coll_next    = coll_reg | coll_evt;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_idx_next  = s_axi_awaddr[3:2];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            wd_next     = s_axi_wdata;
            ws_next     = s_axi_wstrb;
        end
        do_wr = aw_held_reg & w_held_reg & ~bvalid_reg;
        if (do_wr) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `DPR_RESP_OKAY;
            case (aw_idx_reg)
                `DPR_IDX_CTRL: begin
                    for (int b = 0; b < 4; b++)
                        if (ws_reg[b])
                            ctrl_next[b*8 +: 8] = wd_reg[b*8 +: 8];
                end
                `DPR_IDX_STAT: begin
                    if (ws_reg[0] && wd_reg[`DPR_F_COLL])
                        coll_next = coll_evt;
                end
                default: bresp_next = `DPR_RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = `DPR_RESP_OKAY;
            rdata_next  = '0;
            case (ar_idx)
                `DPR_IDX_CTRL: rdata_next = ctrl_reg;
                `DPR_IDX_STAT: begin
                    rdata_next[`DPR_F_SLEEP] = sleep_reg;
                    rdata_next[`DPR_F_COLL]  = coll_reg;
                end
                default: rresp_next = `DPR_RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        awready_next = ~aw_held_next & ~bvalid_next;
        wready_next  = ~w_held_next & ~bvalid_next;
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_idx_reg  <= `DPR_IDX_CTRL;
            wd_reg      <= '0;
            ws_reg      <= '0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `DPR_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `DPR_RESP_OKAY;
            rdata_reg   <= '0;
            ctrl_reg    <= `DPR_CTRL_RST;
            coll_reg    <= 1'b0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            aw_idx_reg  <= aw_idx_next;
            wd_reg      <= wd_next;
            ws_reg      <= ws_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            ctrl_reg    <= ctrl_next;
            coll_reg    <= coll_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence full_write_a;
        port_a_en && (port_a_we == 4'hF) && !power_gate && !ctrl_reg[`DPR_F_CASC]
            && !(port_b_en && (|port_b_we));
    endsequence

    sequence commit_a;
        ##1 wr[0] && !wr[1];
    endsequence

    wr_store_a: assert property (full_write_a ##0 commit_a |=>
        mem[$past(eaddr[0])] == $past(wdata_reg[0]))
        else $error("port A write not stored");
    wr_first_a: assert property (wr[0] && acc[0] && !csel[0]
        && we_reg[0] == 4'hF && cfg_wm[0] == DPR_WM_WRITE_FIRST
        |=> lat_reg[0] == $past(wdata_reg[0]))
        else $error("write-first output wrong");
    no_change_a: assert property (wr[0] && cfg_wm[0] == DPR_WM_NO_CHANGE
        |=> $stable(lat_reg[0]))
        else $error("no-change output moved");
    hold_out_a: assert property (!port_a_en && !cfg_loff[0]
        ##1 !acc[0] |=> $stable(lat_reg[0]))
        else $error("output not held while idle");
    pipe_delay_a: assert property (cfg_pipe[0] && $past(cfg_pipe[0])
        |-> port_a_rdata == $past(lat_reg[0]))
        else $error("pipelined output not one cycle late");
    // The output word follows the stage setting of the edge that loaded it
    no_pipe_b: assert property (!cfg_pipe[1] && !$past(cfg_pipe[1])
        |-> port_b_rdata == casc_b_out)
        else $error("unpipelined output not direct");
    gated_hold: assert property (power_gate |=> (!wr[0] && !wr[1])
        ##1 $stable(lat_reg))
        else $error("array active while gated");
    split_bank: assert property (cfg_split && wr[1]
        |-> eaddr[1][`DPR_AW-1] && !eaddr[0][`DPR_AW-1])
        else $error("split halves not separated");
    casc_pass_a: assert property (acc[0] && csel[0]
        |=> casc_a_out == $past(casc_reg[0]))
        else $error("cascade data not passed");
    resp_bound: assert property (aw_held_reg && w_held_reg && !bvalid_reg
        |=> bvalid_reg)
        else $error("write response late");

endmodule // dpr_ram

// ===== dpr_fabric_b.sv
`timescale 1ns/1ps
`include "dpr_map.svh"

// ----------------------------------------------------------------------
// Fabric user logic driving port B
// ----------------------------------------------------------------------
module dpr_fabric_b (
    input  wire logic                  go,
    input  wire logic [`DPR_NBYTE-1:0] we,
    input  wire logic [`DPR_PAW-1:0]   addr,
    input  wire logic [`DPR_DW-1:0]    wdata,
    input  wire logic [`DPR_NBYTE-1:0] a_we,
    input  wire logic [`DPR_PAW-1:0]   a_addr,
    input  wire logic                  a_en,
    input  wire logic                  gated,
    output logic                       port_b_en,
    output logic      [`DPR_NBYTE-1:0] port_b_we,
    output logic      [`DPR_PAW-1:0]   port_b_addr,
    output logic      [`DPR_DW-1:0]    port_b_wdata
);
    logic clash;
    // Same word written by both ports keeps only port B's word, so hold back
    assign clash        = a_en && (a_we != 4'h0) && (we != 4'h0) && (a_addr == addr);
    // No access while the array is gated
    assign port_b_en    = go && !gated && !clash;
    assign port_b_we    = port_b_en ? we : 4'h0;
    assign port_b_addr  = addr;
    // Idle data lines carry the inverted word so a stale word is never mistaken for a fresh one
    assign port_b_wdata = port_b_en ? wdata : ~wdata;
endmodule // dpr_fabric_b

// ===== tb_top.sv
`timescale 1ns/1ps
`include "dpr_map.svh"

module tb_top;
    import dpr_pkg::*;
    logic clock, reset_n, port_a_en, power_gate, b_go;
    logic [3:0]  port_a_we, b_we, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [10:0] port_a_addr, b_addr;
    logic [35:0] port_a_wdata, b_wdata, port_a_rdata, port_b_rdata;
    logic [35:0] casc_a_in, casc_a_out, casc_b_out, port_b_wdata, casc_b_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        port_b_en;
    logic [3:0]  port_b_we;
    logic [10:0] port_b_addr;
    int          n_fail, tests_run;

    dpr_fabric_b dpr_fabric_b_inst (.go(b_go), .we(b_we), .addr(b_addr), .wdata(b_wdata),
        .a_we(port_a_we), .a_addr(port_a_addr), .a_en(port_a_en), .gated(power_gate),
        .port_b_en(port_b_en), .port_b_we(port_b_we), .port_b_addr(port_b_addr),
        .port_b_wdata(port_b_wdata));
    dpr_ram dpr_ram_inst (.clock(clock), .reset_n(reset_n), .port_a_en(port_a_en),
        .port_a_we(port_a_we), .port_a_addr(port_a_addr), .port_a_wdata(port_a_wdata),
        .port_a_rdata(port_a_rdata), .port_b_en(port_b_en), .port_b_we(port_b_we),
        .port_b_addr(port_b_addr), .port_b_wdata(port_b_wdata), .port_b_rdata(port_b_rdata),
        .casc_a_in(casc_a_in), .casc_b_in(casc_b_in), .casc_a_out(casc_a_out),
        .casc_b_out(casc_b_out), .power_gate(power_gate), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk36(input logic [35:0] g, input logic [35:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: word got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: reg got %h want %h", $time, g, e);
        end
    endtask
    task automatic hang(input int i);
        if (i >= 50) begin
            n_fail++;
            $display("Error %0t: handshake timeout", $time);
            stop_test();
        end
    endtask

    // ------------------------------------------------------------------
    // Bus and port drivers
    // ------------------------------------------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int  i;
        bit  aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50 && (aw || w); i++) begin
            @(posedge clock);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        hang(i);
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (s_axi_bvalid === 1'b1) break;
        end
        hang(i);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) break;
        end
        hang(i);
        s_axi_arvalid <= 1'b0;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (s_axi_rvalid === 1'b1) break;
        end
        hang(i);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic ctrl(input logic [31:0] d);
        axi_wr(4'h0, d, rs);
        chk32({30'h0, rs}, {30'h0, `DPR_RESP_OKAY});
    endtask
    // One access; pp also checks the word one edge early, before the output stage edge
    task automatic mem(input bit pb, input logic [3:0] we, input logic [10:0] ad,
                       input logic [35:0] wd, input logic [35:0] ex, input bit pp,
                       input logic [35:0] early);
        if (pb) begin
            b_go <= 1'b1; b_we <= we; b_addr <= ad; b_wdata <= wd;
        end else begin
            port_a_en <= 1'b1; port_a_we <= we; port_a_addr <= ad; port_a_wdata <= wd;
        end
        @(posedge clock);
        if (pb) begin
            b_go <= 1'b0; b_we <= 4'h0;
        end else begin
            port_a_en <= 1'b0; port_a_we <= 4'h0;
        end
        @(posedge clock);
        // Look at the falling edge, drive again only on a rising one
        @(negedge clock);
        if (pp)
            chk36(pb ? port_b_rdata : port_a_rdata, early);
        @(posedge clock);
        @(negedge clock);
        chk36(pb ? port_b_rdata : port_a_rdata, ex);
        @(posedge clock);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk36(port_a_rdata, `DPR_DATA_RST);
        axi_rd(4'h0, rd, rs);
        chk32(rd, `DPR_CTRL_RST);
        axi_rd(4'h4, rd, rs);
        chk32(rd, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_rw();
        ctrl(32'h0000_0028);
        mem(0, 4'hF, 11'h014, 36'h1_2345_6789, 36'h1_2345_6789, 0, 0);
        mem(0, 4'h0, 11'h014, 36'h0, 36'h1_2345_6789, 0, 0);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk36(port_a_rdata, 36'h1_2345_6789);
        @(posedge clock);
        $display("test rw done");
    endtask
    task automatic t_indep();
        fork
            mem(0, 4'hF, 11'h01E, 36'hA_AAAA_0001, 36'hA_AAAA_0001, 0, 0);
            mem(1, 4'hF, 11'h01F, 36'h5_5555_0002, 36'h5_5555_0002, 0, 0);
        join
        fork
            mem(0, 4'h0, 11'h01F, 36'h0, 36'h5_5555_0002, 0, 0);
            mem(1, 4'h0, 11'h01E, 36'h0, 36'hA_AAAA_0001, 0, 0);
        join
        $display("test indep done");
    endtask
    task automatic t_gate();
        mem(0, 4'hF, 11'h028, 36'h0_0F0F_0F0F, 36'h0_0F0F_0F0F, 0, 0);
        power_gate <= 1'b1;
        repeat (2) @(posedge clock);
        axi_rd(4'h4, rd, rs);
        chk32(rd & 32'h1, 32'h1);
        mem(0, 4'hF, 11'h028, 36'hF_0000_0000, 36'h0_0F0F_0F0F, 0, 0);
        power_gate <= 1'b0;
        repeat (2) @(posedge clock);
        mem(0, 4'h0, 11'h028, 36'h0, 36'h0_0F0F_0F0F, 0, 0);
        $display("test gate done");
    endtask
    task automatic t_wmode();
        logic [35:0] o, n;
        for (int m = 0; m < 3; m++) begin
            o = 36'h3_0000_0100 + m;
            n = 36'hC_0000_0200 + m;
            ctrl(32'h0000_0008);
            mem(0, 4'hF, 11'h014, o, o, 0, 0);
            ctrl(m << `DPR_F_WM_A);
            mem(0, 4'hF, 11'h014, n, (m == 1) ? n : o, 0, 0);
        end
        $display("test wmode done");
    endtask
    task automatic t_pipe();
        ctrl(32'h0000_0000);
        mem(0, 4'h0, 11'h01E, 36'h0, 36'hA_AAAA_0001, 0, 0);
        ctrl(32'h0000_0002);
        mem(0, 4'h0, 11'h01F, 36'h0, 36'h5_5555_0002, 1, 36'hA_AAAA_0001);
        $display("test pipe done");
    endtask
    task automatic t_casc();
        ctrl(32'h0000_0200);
        casc_a_in <= 36'h9_8765_4321;
        mem(0, 4'h0, 11'h01E, 36'h0, 36'hA_AAAA_0001, 0, 0);
        chk36(casc_a_out, 36'hA_AAAA_0001);
        mem(0, 4'h0, 11'h405, 36'h0, 36'h9_8765_4321, 0, 0);
        casc_b_in <= 36'h6_789A_BCDE;
        mem(1, 4'h0, 11'h405, 36'h0, 36'h6_789A_BCDE, 0, 0);
        chk36(casc_b_out, 36'h6_789A_BCDE);
        $display("test casc done");
    endtask
    task automatic t_split();
        ctrl(32'h0000_0029);
        mem(0, 4'hF, 11'h005, 36'h1_1111_0005, 36'h1_1111_0005, 0, 0);
        mem(1, 4'hF, 11'h005, 36'h2_2222_0005, 36'h2_2222_0005, 0, 0);
        mem(0, 4'h0, 11'h005, 36'h0, 36'h1_1111_0005, 0, 0);
        ctrl(32'h0000_0000);
        mem(0, 4'h0, 11'h205, 36'h0, 36'h2_2222_0005, 0, 0);
        $display("test split done");
    endtask
    task automatic t_loff();
        ctrl(32'h0000_0080);
        port_a_addr <= 11'h028;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk36(port_a_rdata, 36'h0_0F0F_0F0F);
        @(posedge clock);
        $display("test loff done");
    endtask
    task automatic t_unmap();
        axi_rd(4'h8, rd, rs);
        chk32({30'h0, rs}, {30'h0, `DPR_RESP_SLVERR});
        chk32(rd, 32'h0000_0000);
        axi_wr(4'hC, 32'hFFFF_FFFF, rs);
        chk32({30'h0, rs}, {30'h0, `DPR_RESP_SLVERR});
        axi_rd(4'h0, rd, rs);
        chk32(rd, 32'h0000_0200);
        $display("test unmap done");
    endtask

    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    initial begin
        n_fail = 0; tests_run = 0; reset_n = 0; power_gate = 0;
        port_a_en = 0; port_a_we = 0; port_a_addr = 0; port_a_wdata = 0;
        b_go = 0; b_we = 0; b_addr = 0; b_wdata = 0; casc_a_in = 0; casc_b_in = 0;
        s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF;
        s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 0; s_axi_arvalid = 0;
        s_axi_rready = 0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset();
        t_rw();
        t_indep();
        t_gate();
        t_wmode();
        t_pipe();
        t_casc();
        t_unmap();
        t_split();
        t_loff();
        stop_test();
    end
endmodule // tb_top
